// ===== rtl/pwr_dev_end.sv
// Purpose: serial target of a single-channel potentiometer wiper register
// Assumes: link lines synchronous to pclk, bit quarters of several cycles
// Notes:   no clock stretching; wiper moves at the data byte, storage at stop
`include "pwr_map.svh"
module pwr_dev_end
	import pwr_pkg::*;
#(
	parameter int         PROG_CYCLES = `PWR_PROG_CYCLES,
	parameter logic [7:0] DEVICE_ID   = 8'hA5     // Arbitrary value
)
(
	input  wire logic       pclk,       // System clock
	input  wire logic       presetn,    // Asynchronous reset, low
	pwr_if.dev              bus,        // Serial link
	input  wire logic       wp_n,       // Storage write protect, low
	output logic [7:0]      wiper_tap,  // Tap select to ladder decoder
	output logic            prog_busy   // Programming cycle running
);

	localparam int PW = $clog2(PROG_CYCLES + 1);

	generate
		if (PROG_CYCLES < 1)
		begin : g_chk
			$error("PROG_CYCLES must be at least 1");
		end
	endgenerate

	pwr_dev_state_t state_r;
	pwr_dev_state_t after_r;
	logic [7:0]     sh_r;
	logic [3:0]     cnt_r;
	logic           drive_r;
	logic           scl_q;
	logic           sda_q;
	logic [3:0]     ptr_r;
	logic           vol_r;
	logic [7:0]     start_val_r;
	logic [7:0]     wiper_r;
	logic [7:0]     gp_r [`PWR_REG_GP_LO:`PWR_REG_GP_HI];
	logic           pend_r;
	logic [3:0]     pend_ptr_r;
	logic [7:0]     pend_data_r;
	logic           nv_done_r;
	logic [PW-1:0]  prog_cnt_r;

	logic           scl_rise;
	logic           scl_fall;
	logic           start_c;
	logic           stop_c;
	logic           byte_done;
	logic           ack_c;
	logic           do_wr_c;
	logic           nv_tgt;
	logic           ptr_ok;
	pwr_dev_state_t go_c;
	logic [7:0]     rdata;

	assign scl_rise  = bus.scl & ~scl_q;
	assign scl_fall  = ~bus.scl & scl_q;
	assign start_c   = bus.scl & scl_q & sda_q & ~bus.sda;
	assign stop_c    = bus.scl & scl_q & ~sda_q & bus.sda;
	assign byte_done = scl_fall && cnt_r == 4'h8
		&& (state_r == DS_DEVADDR || state_r == DS_REGADDR || state_r == DS_WDATA);
	assign ptr_ok    = ptr_r != `PWR_REG_RSVD && ptr_r <= `PWR_REG_ACR;
	assign nv_tgt    = (ptr_r == `PWR_REG_WIPER && !vol_r)
		|| (ptr_r >= `PWR_REG_GP_LO && ptr_r <= `PWR_REG_GP_HI);
	assign do_wr_c   = !nv_done_r && ptr_ok && !(nv_tgt && !wp_n);
	assign wiper_tap = wiper_r;
	assign prog_busy = |prog_cnt_r;
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = ~drive_r;

	always_comb
	begin
		if (ptr_r == `PWR_REG_WIPER)
			rdata = vol_r ? wiper_r : start_val_r;
		else if (ptr_r == `PWR_REG_ID)
			rdata = DEVICE_ID;
		else if (ptr_r >= `PWR_REG_GP_LO && ptr_r <= `PWR_REG_GP_HI)
			rdata = gp_r[ptr_r];
		else if (ptr_r == `PWR_REG_ACR)
			rdata = {vol_r, 7'h00};
		else
			rdata = `PWR_RSVD_DATA;
	end

	always_comb
	begin
		ack_c = 1'b0;
		go_c  = DS_IDLE;
		unique case (state_r)
			DS_DEVADDR:
			begin
				ack_c = (sh_r == `PWR_ADDR_WR || sh_r == `PWR_ADDR_RD) && !prog_busy;
				go_c  = sh_r[0] ? DS_RDATA : DS_REGADDR;
			end
			DS_REGADDR:
			begin
				ack_c = sh_r[3:0] != `PWR_REG_RSVD && sh_r <= 8'(`PWR_REG_ACR);
				go_c  = DS_WDATA;
			end
			DS_WDATA:
			begin
				ack_c = do_wr_c && !(ptr_r == `PWR_REG_ACR && sh_r[6:0] != 7'h00);
				go_c  = DS_WDATA;
			end
			default:
			begin
				ack_c = 1'b0;
				go_c  = DS_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
		end
	end

	// Protocol sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= DS_IDLE;
			after_r <= DS_IDLE;
			sh_r    <= 8'h00;
			cnt_r   <= 4'h0;
			drive_r <= 1'b0;
		end
		else if (start_c)
		begin
			state_r <= DS_DEVADDR;
			cnt_r   <= 4'h0;
			drive_r <= 1'b0;
		end
		else if (stop_c)
		begin
			state_r <= DS_IDLE;
			drive_r <= 1'b0;
		end
		else if (byte_done)
		begin
			state_r <= DS_ACK;
			after_r <= ack_c ? go_c : DS_IDLE;
			drive_r <= ack_c;
		end
		else
		begin
			unique case (state_r)
				DS_DEVADDR, DS_REGADDR, DS_WDATA:
				begin
					if (scl_rise && cnt_r < 4'h8)
					begin
						sh_r  <= {sh_r[6:0], bus.sda};
						cnt_r <= cnt_r + 4'h1;
					end
				end
				DS_ACK:
				begin
					if (scl_fall)
					begin
						state_r <= after_r;
						cnt_r   <= (after_r == DS_RDATA) ? 4'h1 : 4'h0;
						sh_r    <= rdata;
						drive_r <= (after_r == DS_RDATA) ? ~rdata[7] : 1'b0;
					end
				end
				DS_RDATA:
				begin
					if (scl_fall && cnt_r == 4'h8)
					begin
						state_r <= DS_MACK;
						drive_r <= 1'b0;
					end
					else if (scl_fall)
					begin
						sh_r    <= {sh_r[6:0], 1'b0};
						drive_r <= ~sh_r[6];
						cnt_r   <= cnt_r + 4'h1;
					end
				end
				DS_MACK:
				begin
					if (scl_rise && bus.sda)
						state_r <= DS_IDLE;
					else if (scl_fall)
					begin
						state_r <= DS_RDATA;
						sh_r    <= rdata;
						drive_r <= ~rdata[7];
						cnt_r   <= 4'h1;
					end
				end
				default:
				begin
					drive_r <= 1'b0;
				end
			endcase
		end
	end

	// Register file and address pointer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ptr_r       <= 4'h0;
			vol_r       <= 1'b0;
			start_val_r <= `PWR_START_RESET;
			wiper_r     <= `PWR_START_RESET;
			for (int i = `PWR_REG_GP_LO; i <= `PWR_REG_GP_HI; i++)
				gp_r[i] <= `PWR_GP_RESET;
			pend_r      <= 1'b0;
			pend_ptr_r  <= 4'h0;
			pend_data_r <= 8'h00;
			nv_done_r   <= 1'b0;
		end
		else if (start_c)
		begin
			pend_r    <= 1'b0;
			nv_done_r <= 1'b0;
		end
		else if (stop_c)
		begin
			pend_r <= 1'b0;
			if (pend_r && pend_ptr_r == `PWR_REG_WIPER)
				start_val_r <= pend_data_r;
			else if (pend_r)
				gp_r[pend_ptr_r] <= pend_data_r;
		end
		else if (byte_done && state_r == DS_REGADDR && ack_c)
			ptr_r <= sh_r[3:0];
		else if (byte_done && state_r == DS_WDATA)
		begin
			ptr_r <= ptr_r + 4'h1;
			if (nv_done_r)
				pend_r <= 1'b0;
			if (do_wr_c)
			begin
				if (ptr_r == `PWR_REG_WIPER)
					wiper_r <= sh_r;
				if (ptr_r == `PWR_REG_ACR)
					vol_r <= sh_r[`PWR_VOL_BIT];
				if (nv_tgt)
				begin
					pend_r      <= 1'b1;
					pend_ptr_r  <= ptr_r;
					pend_data_r <= sh_r;
					nv_done_r   <= 1'b1;
				end
			end
		end
		else if (state_r == DS_RDATA && scl_fall && cnt_r == 4'h8)
			ptr_r <= ptr_r + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prog_cnt_r <= '0;
		else if (stop_c && pend_r)
			prog_cnt_r <= PW'(PROG_CYCLES);
		else if (prog_busy)
			prog_cnt_r <= prog_cnt_r - PW'(1);
	end

endmodule

// ===== rtl/pwr_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 40 MHz pclk
// Notes:   shared by both ends of the wiper-register link
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH

// Target address bytes
`define PWR_ADDR_WR         8'h50
`define PWR_ADDR_RD         8'h51

// Target register addresses
`define PWR_REG_WIPER       4'h0
`define PWR_REG_ID          4'h1
`define PWR_REG_GP_LO       4'h2
`define PWR_REG_GP_HI       4'h6
`define PWR_REG_RSVD        4'h7
`define PWR_REG_ACR         4'h8
`define PWR_VOL_BIT         7

// Reset and fixed read values
`define PWR_START_RESET     8'h80
`define PWR_GP_RESET        8'h00
`define PWR_RSVD_DATA       8'hFF

// Timing: a quarter of a 400 kHz serial bit
`define PWR_CLK_NS          25
`define PWR_QUARTER_NS      625
`define PWR_QUARTER_CYCLES  ((`PWR_QUARTER_NS + `PWR_CLK_NS - 1) / `PWR_CLK_NS)
`define PWR_PROG_CYCLES     1000

// Host controller APB map
`define PWR_APB_CTRL        8'h00
`define PWR_APB_TXDATA      8'h04
`define PWR_APB_RXDATA      8'h08
`define PWR_APB_STATUS      8'h0C
`define PWR_CTRL_NACK_BIT   3
`define PWR_STAT_BUSY_BIT   0
`define PWR_STAT_NACK_BIT   1

`endif

// ===== rtl/pwr_pkg.sv
// Purpose: shared types of the wiper-register link
// Assumes: nothing
// Notes:   constants live in pwr_map.svh
package pwr_pkg;

	typedef enum logic [2:0] {
		DS_IDLE    = 3'h0,
		DS_DEVADDR = 3'h1,
		DS_REGADDR = 3'h2,
		DS_WDATA   = 3'h3,
		DS_ACK     = 3'h4,
		DS_RDATA   = 3'h5,
		DS_MACK    = 3'h6
	} pwr_dev_state_t;

	typedef enum logic [2:0] {
		CMD_NONE  = 3'h0,
		CMD_START = 3'h1,
		CMD_STOP  = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_READ  = 3'h4
	} pwr_cmd_t;

endpackage

// ===== rtl/pwr_if.sv
// Purpose: open-drain serial link between host controller and device
// Assumes: both ends clocked by the same pclk
// Notes:   a line is low when any end enables its low drive
interface pwr_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport host (
		output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
		input  scl, sda
	);
	modport dev (
		output dev_sda_o, dev_sda_oe_n,
		input  scl, sda
	);
endinterface

// ===== rtl/pwr_host_end.sv
// Purpose: serial host controller driven from APB registers
// Assumes: single target, no clock stretching, bus free at reset
// Notes:   one command at a time; commands while busy are dropped
`include "pwr_map.svh"
module pwr_host_end
	import pwr_pkg::*;
#(
	parameter int QUARTER_CYCLES = `PWR_QUARTER_CYCLES
)
(
	input  wire logic        pclk,     // System clock
	input  wire logic        presetn,  // Asynchronous reset, low
	input  wire logic [7:0]  paddr,    // APB address
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB enable
	input  wire logic        pwrite,   // APB write
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error
	pwr_if.host              bus       // Serial link
);

	localparam int QW = $clog2(QUARTER_CYCLES + 1);

	generate
		if (QUARTER_CYCLES < 1)
		begin : g_chk
			$error("QUARTER_CYCLES must be at least 1");
		end
	endgenerate

	pwr_cmd_t      cmd_r;
	logic [7:0]    tx_r;
	logic [7:0]    rx_r;
	logic          nack_r;
	logic          got_nack_r;
	logic          scl_hold_r;
	logic [QW-1:0] qcnt_r;
	logic [1:0]    q_r;
	logic [3:0]    bit_r;
	logic          scl_low_r;
	logic          sda_low_r;
	logic [31:0]   prdata_r;
	logic          scl_low_nxt;
	logic          sda_low_nxt;
	logic          busy;
	logic          wr_en;
	logic          q_end;
	pwr_cmd_t      new_cmd;

	assign busy    = cmd_r != CMD_NONE;
	assign wr_en   = psel & penable & pwrite;
	assign q_end   = qcnt_r == QW'(QUARTER_CYCLES - 1);
	assign new_cmd = pwr_cmd_t'(pwdata[2:0]);
	// Zero-wait slave keeps the host engine simple
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = prdata_r;
	assign bus.host_scl_o    = 1'b0;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_scl_oe_n = ~scl_low_r;
	assign bus.host_sda_oe_n = ~sda_low_r;

	// Read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			unique case (paddr)
				`PWR_APB_CTRL:   prdata_r <= {28'h0000000, nack_r, cmd_r};
				`PWR_APB_TXDATA: prdata_r <= {24'h000000, tx_r};
				`PWR_APB_RXDATA: prdata_r <= {24'h000000, rx_r};
				`PWR_APB_STATUS: prdata_r <= {30'h00000000, got_nack_r, busy};
				default:         prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Line levels per command and quarter
	always_comb
	begin
		scl_low_nxt = scl_hold_r;
		sda_low_nxt = 1'b0;
		unique case (cmd_r)
			CMD_START:
			begin
				scl_low_nxt = q_r == 2'h0 || q_r == 2'h3;
				sda_low_nxt = q_r[1];
			end
			CMD_STOP:
			begin
				scl_low_nxt = q_r == 2'h0;
				sda_low_nxt = !q_r[1];
			end
			CMD_WRITE:
			begin
				scl_low_nxt = q_r == 2'h0 || q_r == 2'h3;
				sda_low_nxt = bit_r < 4'h8 && !tx_r[3'h7 - bit_r[2:0]];
			end
			CMD_READ:
			begin
				scl_low_nxt = q_r == 2'h0 || q_r == 2'h3;
				sda_low_nxt = bit_r == 4'h8 && !nack_r;
			end
			default:
			begin
				scl_low_nxt = scl_hold_r;
				sda_low_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
		end
		else
		begin
			scl_low_r <= scl_low_nxt;
			sda_low_r <= sda_low_nxt;
		end
	end

	// Command register and bit engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_r      <= CMD_NONE;
			tx_r       <= 8'h00;
			rx_r       <= 8'h00;
			nack_r     <= 1'b0;
			got_nack_r <= 1'b0;
			scl_hold_r <= 1'b0;
			qcnt_r     <= '0;
			q_r        <= 2'h0;
			bit_r      <= 4'h0;
		end
		else if (!busy)
		begin
			if (wr_en && paddr == `PWR_APB_TXDATA)
				tx_r <= pwdata[7:0];
			if (wr_en && paddr == `PWR_APB_CTRL && pwdata[2:0] != 3'h0
				&& pwdata[2:0] <= 3'h4)
			begin
				cmd_r  <= new_cmd;
				nack_r <= pwdata[`PWR_CTRL_NACK_BIT];
				qcnt_r <= '0;
				q_r    <= 2'h0;
				bit_r  <= 4'h0;
			end
		end
		else if (!q_end)
			qcnt_r <= qcnt_r + QW'(1);
		else
		begin
			qcnt_r <= '0;
			q_r    <= q_r + 2'h1;
			if (q_r == 2'h2 && cmd_r == CMD_WRITE && bit_r == 4'h8)
				got_nack_r <= bus.sda;
			if (q_r == 2'h2 && cmd_r == CMD_READ && bit_r < 4'h8)
				rx_r <= {rx_r[6:0], bus.sda};
			if (q_r == 2'h3)
			begin
				bit_r <= bit_r + 4'h1;
				if (cmd_r == CMD_START || cmd_r == CMD_STOP || bit_r == 4'h8)
				begin
					cmd_r      <= CMD_NONE;
					scl_hold_r <= cmd_r != CMD_STOP;
				end
			end
		end
	end

endmodule

// ===== sim/pwr_link_assertions.sv
// Purpose: checks on the serial link and wiper output
// Assumes: one pclk domain, host quarter of 4 cycles
// Notes:   watches interface signals as plain inputs
module pwr_link_assertions
#(
	parameter int PROG_CYCLES = 20
)
(
	input wire logic       pclk,         // System clock
	input wire logic       presetn,      // Reset, low
	input wire logic       scl,          // Resolved clock line
	input wire logic       sda,          // Resolved data line
	input wire logic       dev_sda_oe_n, // Device pulls data, low
	input wire logic       wp_n,         // Write protect, low
	input wire logic [7:0] wiper_tap,    // Tap select
	input wire logic       prog_busy     // Programming cycle
);
	int cnt_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= 0;
		else
			cnt_r <= prog_busy ? cnt_r + 1 : 0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_WIPER_RST: assert property ($rose(presetn) |-> wiper_tap == 8'h80)
		else $error("wiper not at start value after reset");
	AST_LINES_IDLE: assert property ($rose(presetn) |-> scl && sda && dev_sda_oe_n)
		else $error("link not idle after reset");
	AST_WIPER_SCL_LOW: assert property (!$stable(wiper_tap) |-> !scl)
		else $error("wiper moved outside a low clock phase");
	AST_DEV_SDA_SCL_LOW: assert property (!$stable(dev_sda_oe_n) |-> !scl)
		else $error("device changed data while clock high");
	AST_SCL_LOW_HOLD: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low phase too short");
	AST_PROG_AFTER_STOP: assert property ($rose(prog_busy) |-> scl && sda)
		else $error("programming began without stop");
	AST_WP_NO_PROG: assert property (!wp_n |-> !$rose(prog_busy))
		else $error("programming began while protected");
	AST_PROG_QUIET: assert property (prog_busy && $past(prog_busy) |-> dev_sda_oe_n)
		else $error("device answered while programming");
	AST_PROG_LEN: assert property ($fell(prog_busy) |->
		cnt_r >= PROG_CYCLES - 1 && cnt_r <= PROG_CYCLES + 1)
		else $error("programming length wrong");

	cover property ($rose(prog_busy));
	cover property ($fell(dev_sda_oe_n));
	cover property (!$stable(wiper_tap));
endmodule

// ===== sim/tb_pot_wiper_register_i2c_access.sv
// Purpose: both ends joined, host driven over APB
// Assumes: quarter of 4 cycles, short programming time
// Notes:   expectations from the register map only
`include "pwr_map.svh"
module tb_pot_wiper_register_i2c_access;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         PROG   = 400;
	localparam logic [7:0] DEV_ID = 8'h3C; // Arbitrary value
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wp_n = 1;
	logic [7:0]  paddr = 8'h00, wiper_tap, rv, d;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, prog_busy, nk;
	int          err_count = 0, num_checks = 0, seed = 45, n;

	always #12.5 pclk = ~pclk;

	pwr_if lnk();
	pwr_host_end #(.QUARTER_CYCLES(4)) u_pwr_host_end (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lnk.host));
	pwr_dev_end #(.PROG_CYCLES(PROG), .DEVICE_ID(DEV_ID)) u_pwr_dev_end (.pclk(pclk),
		.presetn(presetn), .bus(lnk.dev), .wp_n(wp_n), .wiper_tap(wiper_tap),
		.prog_busy(prog_busy));
	pwr_link_assertions #(.PROG_CYCLES(PROG)) u_pwr_link_assertions (.pclk(pclk),
		.presetn(presetn), .scl(lnk.scl), .sda(lnk.sda), .dev_sda_oe_n(lnk.dev_sda_oe_n),
		.wp_n(wp_n), .wiper_tap(wiper_tap), .prog_busy(prog_busy));

	task stop_test;
	begin
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	end
	endtask

	// Hung wait counts as a mismatch
	task hang;
	begin
		chk(8'h01, 8'h00);
		stop_test;
	end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
		int k;
	begin
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			if (++k > 50)
				hang;
			@(posedge pclk);
		end
		rdat = prdata;
		chk({7'h0, pslverr}, 8'h00);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask

	// One link command, then poll until idle
	task op(input logic [3:0] c, input logic [7:0] t);
		int k;
	begin
		k = 0;
		apb(1'b1, `PWR_APB_TXDATA, {24'h0, t});
		apb(1'b1, `PWR_APB_CTRL, {28'h0, c});
		do
		begin
			if (++k > 500)
				hang;
			apb(1'b0, `PWR_APB_STATUS, 32'h0);
		end
		while (rdat[0] !== 1'b0);
		nk = rdat[1];
		if (c[2])
		begin
			apb(1'b0, `PWR_APB_RXDATA, 32'h0);
			rv = rdat[7:0];
		end
	end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] dv, input logic e);
	begin
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_WR);
		op(4'h3, a);
		op(4'h3, dv);
		chk({7'h0, nk}, {7'h0, e});
		op(4'h2, 8'h00);
	end
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
	begin
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_WR);
		op(4'h3, a);
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_RD);
		op(4'hC, 8'h00);
		chk(rv, e);
		op(4'h2, 8'h00);
	end
	endtask

	// Refusal of address byte or register byte
	task nak(input logic [7:0] b0, input logic [7:0] b1, input logic e0);
	begin
		op(4'h1, 8'h00);
		op(4'h3, b0);
		chk({7'h0, nk}, {7'h0, e0});
		if (!e0)
		begin
			op(4'h3, b1);
			chk({7'h0, nk}, 8'h01);
		end
		op(4'h2, 8'h00);
	end
	endtask

	task wait_prog;
		int k;
	begin
		k = 0;
		while (prog_busy !== 1'b0)
		begin
			if (++k > 2000)
				hang;
			@(posedge pclk);
		end
	end
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(wiper_tap, `PWR_START_RESET);
		rd(8'h00, 8'h80);
		wr(8'h08, 8'h80, 1'b0);
		for (n = 0; n < 4; n++)
		begin
			d = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($random(seed));
			wr(8'h00, d, 1'b0);
			chk(wiper_tap, d);
			rd(8'h00, d);
		end
		wr(8'h08, 8'h00, 1'b0);
		rd(8'h00, 8'h80);
		d = 8'($random(seed));
		wr(8'h00, d, 1'b0);
		chk(wiper_tap, d);
		nak(`PWR_ADDR_WR, 8'h00, 1'b1);
		wait_prog;
		rd(8'h00, d);
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_WR);
		op(4'h3, 8'h00);
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_RD);
		op(4'h4, 8'h00);
		chk(rv, d);
		op(4'hC, 8'h00);
		chk(rv, DEV_ID);
		op(4'h2, 8'h00);
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_RD);
		op(4'hC, 8'h00);
		chk(rv, `PWR_GP_RESET);
		op(4'h2, 8'h00);
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_WR);
		op(4'h3, 8'h08);
		op(4'h3, 8'h00);
		chk({7'h0, nk}, 8'h00);
		op(4'h3, 8'h22);
		chk({7'h0, nk}, 8'h01);
		op(4'h2, 8'h00);
		wait_prog;
		// Restart instead of stop drops the stored byte
		op(4'h1, 8'h00);
		op(4'h3, `PWR_ADDR_WR);
		op(4'h3, 8'h03);
		op(4'h3, 8'h33);
		rd(8'h03, 8'h00);
		chk({7'h0, prog_busy}, 8'h00);
		wp_n <= 1'b0;
		wr(8'h04, 8'h5A, 1'b1);
		wp_n <= 1'b1;
		rd(8'h04, 8'h00);
		nak(8'h52, 8'h00, 1'b1);
		nak(`PWR_ADDR_WR, 8'h07, 1'b0);
		nak(`PWR_ADDR_WR, 8'h09, 1'b0);
		stop_test;
	end
endmodule
